// ===== rtl/vba_pkg.sv
// Shared types and constants for the byte arithmetic and accumulator datapath.
// Assumes one core clock and that the issuing pipeline presents both source vectors
// together with the instruction word.
`default_nettype none

package vba_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry.
  localparam int unsigned SLICES = 8;
  localparam int unsigned ACC_W = 48;
  localparam int unsigned BACC_W = 18;
  localparam int unsigned MUL_W = 16;

  // Byte accumulators inside one slice accumulator.
  localparam int unsigned BACC_HI_LSB = 18;
  localparam int unsigned BACC_LO_LSB = 0;

  // Thirds of a slice accumulator picked by the element field of a sum reduction.
  localparam int unsigned THIRD_HI_LSB = 32;
  localparam int unsigned THIRD_MID_LSB = 16;
  localparam int unsigned THIRD_LO_LSB = 0;
  localparam logic [3:0] THIRD_SEL_HI = 4'h0;
  localparam logic [3:0] THIRD_SEL_MID = 4'h1;
  localparam logic [3:0] THIRD_SEL_LO = 4'h2;

  // Reset values.
  localparam logic [ACC_W-1:0] ACC_RST = 48'h0;
  localparam logic [4:0] VREG_RST = 5'h00;

  // Signed 16-bit clamp limits for the sum reduction, and the unsigned byte clamp limit.
  localparam logic signed [19:0] SUM_MAX = 20'sh07fff;
  localparam logic signed [19:0] SUM_MIN = -20'sh08000;
  localparam logic signed [17:0] BYTE_MAX = 18'sh000ff;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction word and function codes.
  localparam logic [5:0] COPROCESSOR_MAJOR_OPCODE = 6'h12;

  typedef struct packed {
    logic [5:0] major;
    logic co;
    logic [3:0] elem;
    logic [4:0] second_src_vreg;
    logic [4:0] first_src_vreg;
    logic [4:0] dest_vreg;
    logic [5:0] func;
  } vba_instr_t;

  typedef enum logic [5:0] {
    BYTE_ADD_OP = 6'h20,
    BYTE_ADD_ACCUM_OP = 6'h21,
    BYTE_SUB_OP = 6'h22,
    BYTE_SUB_ACCUM_OP = 6'h23,
    ABS_DIFF_SUM_OP = 6'h24,
    ABS_DIFF_SUM_ACCUM_OP = 6'h25,
    BYTE_PAIR_SUM_OP = 6'h26,
    BYTE_PAIR_SUM_ACCUM_OP = 6'h27,
    BYTE_MUL_LOAD_OP = 6'h28,
    BYTE_MUL_LOAD_NEG_OP = 6'h29,
    BYTE_MUL_ADD_OP = 6'h2a,
    BYTE_MUL_SUB_OP = 6'h2b,
    ACCUM_SUM_REDUCE_OP = 6'h2c
  } vba_func_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef logic [SLICES-1:0][15:0] vba_vec_t;

  typedef struct packed {
    logic valid;
    vba_instr_t instr;
    vba_vec_t first_src;
    vba_vec_t second_src;
  } vba_issue_t;

  typedef struct packed {
    logic valid;
    logic [4:0] dest_vreg;
    vba_vec_t data;
  } vba_wb_t;

  typedef struct packed {
    logic [SLICES-1:0][ACC_W-1:0] acc;
    vba_wb_t wb;
    logic illegal;
  } vba_state_t;

endpackage : vba_pkg

`default_nettype wire

// ===== rtl/vba_unit.sv
// Byte arithmetic and accumulator datapath of the vector unit, eight slices wide.
// Assumes the issuing pipeline gives one instruction per cycle with both source
// vectors already read from the vector_register_file, and takes the write-back.
//
// Contract
// - Byte add sums matching bytes, rounds into accumulator, writes shifted result.
// - Byte subtract takes second from first byte, same rounding, load, shift path.
// - Accumulating byte add and subtract add to accumulator, element only shifts.
// - Absolute difference loads sum of high and low absolute differences, element unused.
// - Accumulating absolute difference adds that sum to the accumulator.
// - Both absolute difference operations write the first source to the destination.
// - Byte pair sum adds all four bytes, loads accumulator, writes shifted result.
// - Accumulating byte pair sum adds to accumulator, element only shifts.
// - Byte multiplies take the matching second-source byte pair (element-selected in scalar form) times first source.
// - Multiply-load replaces the accumulator with the byte products.
// - Multiply-load-negated loads the negated byte products.
// - Multiply-add adds byte products to the accumulator.
// - Multiply-subtract subtracts byte products from the accumulator.
// - Byte products are 16 bits in 16-bit portions; overflow wraps undetected.
// - Accumulator operations neither clamp nor round unless stated; rounding control ignored.
// - Sum reduction adds eight selected thirds, clamps signed 16, writes low halfword.
// - Sum reduction element is 0, 1 or 2 for high, middle, low third.
// - Sum reduction ignores both source register fields.
// - Byte accumulators are 18 bits; loads initialise their two top bits.
// - Shifted byte results clamp to 0 through 255 before write-back.
// - Rounding adds two to the power element minus one on accumulator entry.
// - Byte operands are unsigned 0 through 255.
`default_nettype none

module vba_unit (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_i,
  // Instruction issue.
  input wire vba_pkg::vba_issue_t issue_i,
  // Write-back to the vector register file.
  output vba_pkg::vba_wb_t wb_o,
  output logic illegal_o
);

  import vba_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Arithmetic shift of an 18-bit byte accumulator, then unsigned byte clamp.
  function automatic logic [7:0] vba_clamp_byte(input logic [BACC_W-1:0] v,
                                                input logic [2:0] sh);
    logic signed [BACC_W-1:0] t;
    t = $signed(v) >>> sh;
    if (t < 18'sh0) begin
      return 8'h00;
    end else if (t > BYTE_MAX) begin
      return 8'hff;
    end
    return t[7:0];
  endfunction : vba_clamp_byte

  // Zero-extend an unsigned byte to byte accumulator width.
  function automatic logic [BACC_W-1:0] vba_ext(input logic [7:0] b);
    return {10'h000, b};
  endfunction : vba_ext

  // Absolute difference of two unsigned bytes.
  function automatic logic [BACC_W-1:0] vba_absdiff(input logic [7:0] a,
                                                    input logic [7:0] b);
    return (a >= b) ? vba_ext(8'(a - b)) : vba_ext(8'(b - a));
  endfunction : vba_absdiff

  // Accumulate a 16-bit product into the low 16 bits, keeping the two top bits.
  function automatic logic [BACC_W-1:0] vba_mac(input logic [BACC_W-1:0] acc,
                                                input logic [MUL_W-1:0] p,
                                                input logic sub);
    logic [MUL_W-1:0] r;
    r = sub ? (acc[MUL_W-1:0] - p) : (acc[MUL_W-1:0] + p);
    return {acc[BACC_W-1:MUL_W], r};
  endfunction : vba_mac

  ////////////////////////////////////////////////////////////////////////////
  // State.

  vba_state_t st_r;
  vba_state_t st_nxt;

  vba_instr_t ins;
  vba_func_t fn;
  logic legal;
  logic known;
  logic [2:0] sh;
  logic [BACC_W-1:0] rnd;
  logic [15:0] mul_src;
  logic [BACC_W-1:0] b_hi;
  logic [BACC_W-1:0] b_lo;
  logic [BACC_W-1:0] pair;
  logic [MUL_W-1:0] p_hi;
  logic [MUL_W-1:0] p_lo;
  logic [15:0] third;
  logic signed [19:0] red;
  logic [15:0] red_clamped;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    st_nxt = st_r;
    st_nxt.wb.valid = 1'b0;
    st_nxt.illegal = 1'b0;
    ins = issue_i.instr;
    fn = vba_func_t'(ins.func);
    // Only bit 25 set under the coprocessor major opcode reaches this unit.
    legal = issue_i.valid && (ins.major == COPROCESSOR_MAJOR_OPCODE) && ins.co;
    known = 1'b1;
    // Bit 3 of the element picks the scalar multiply form; the shift uses only the low three bits.
    sh = ins.elem[2:0];
    // Rounding control register is deliberately not an input of this unit.
    rnd = (sh == 3'h0) ? 18'h0 : BACC_W'(18'h1 << (sh - 3'h1));
    // Scalar form picks one halfword of the second source for every slice.
    mul_src = 16'h0;
    b_hi = 18'h0;
    b_lo = 18'h0;
    pair = 18'h0;
    p_hi = 16'h0;
    p_lo = 16'h0;
    third = 16'h0;
    red = 20'sh0;
    red_clamped = 16'h0;

    for (int s = 0; s < SLICES; s++) begin
      b_hi = st_r.acc[s][BACC_HI_LSB +: BACC_W];
      b_lo = st_r.acc[s][BACC_LO_LSB +: BACC_W];
      mul_src = ins.elem[3] ? issue_i.second_src[ins.elem[2:0]]
                            : issue_i.second_src[s];
      p_hi = MUL_W'(issue_i.first_src[s][15:8] * mul_src[15:8]);
      p_lo = MUL_W'(issue_i.first_src[s][7:0] * mul_src[7:0]);
      pair = BACC_W'(vba_ext(issue_i.first_src[s][15:8]) + vba_ext(issue_i.second_src[s][15:8])
                     + vba_ext(issue_i.first_src[s][7:0]) + vba_ext(issue_i.second_src[s][7:0]));
      unique case (fn)
        BYTE_ADD_OP: begin
          b_hi = BACC_W'(vba_ext(issue_i.first_src[s][15:8])
                         + vba_ext(issue_i.second_src[s][15:8]) + rnd);
          b_lo = BACC_W'(vba_ext(issue_i.first_src[s][7:0])
                         + vba_ext(issue_i.second_src[s][7:0]) + rnd);
        end
        BYTE_SUB_OP: begin
          b_hi = BACC_W'(vba_ext(issue_i.first_src[s][15:8])
                         - vba_ext(issue_i.second_src[s][15:8]) + rnd);
          b_lo = BACC_W'(vba_ext(issue_i.first_src[s][7:0])
                         - vba_ext(issue_i.second_src[s][7:0]) + rnd);
        end
        BYTE_ADD_ACCUM_OP: begin
          b_hi = BACC_W'(b_hi + vba_ext(issue_i.first_src[s][15:8])
                         + vba_ext(issue_i.second_src[s][15:8]));
          b_lo = BACC_W'(b_lo + vba_ext(issue_i.first_src[s][7:0])
                         + vba_ext(issue_i.second_src[s][7:0]));
        end
        BYTE_SUB_ACCUM_OP: begin
          b_hi = BACC_W'(b_hi + vba_ext(issue_i.first_src[s][15:8])
                         - vba_ext(issue_i.second_src[s][15:8]));
          b_lo = BACC_W'(b_lo + vba_ext(issue_i.first_src[s][7:0])
                         - vba_ext(issue_i.second_src[s][7:0]));
        end
        ABS_DIFF_SUM_OP: begin
          b_hi = 18'h0;
          b_lo = BACC_W'(vba_absdiff(issue_i.first_src[s][15:8], issue_i.second_src[s][15:8])
                         + vba_absdiff(issue_i.first_src[s][7:0],
                                       issue_i.second_src[s][7:0]));
        end
        ABS_DIFF_SUM_ACCUM_OP: begin
          b_lo = BACC_W'(b_lo
                         + vba_absdiff(issue_i.first_src[s][15:8], issue_i.second_src[s][15:8])
                         + vba_absdiff(issue_i.first_src[s][7:0],
                                       issue_i.second_src[s][7:0]));
        end
        BYTE_PAIR_SUM_OP: begin
          b_hi = 18'h0;
          b_lo = pair;
        end
        BYTE_PAIR_SUM_ACCUM_OP: begin
          b_lo = BACC_W'(b_lo + pair);
        end
        BYTE_MUL_LOAD_OP: begin
          b_hi = {2'b00, p_hi};
          b_lo = {2'b00, p_lo};
        end
        BYTE_MUL_LOAD_NEG_OP: begin
          b_hi = BACC_W'(18'h0 - {2'b00, p_hi});
          b_lo = BACC_W'(18'h0 - {2'b00, p_lo});
        end
        BYTE_MUL_ADD_OP: begin
          b_hi = vba_mac(b_hi, p_hi, 1'b0);
          b_lo = vba_mac(b_lo, p_lo, 1'b0);
        end
        BYTE_MUL_SUB_OP: begin
          b_hi = vba_mac(b_hi, p_hi, 1'b1);
          b_lo = vba_mac(b_lo, p_lo, 1'b1);
        end
        ACCUM_SUM_REDUCE_OP: begin
          // Source fields take no part here.
          unique case (ins.elem)
            THIRD_SEL_HI: third = st_r.acc[s][THIRD_HI_LSB +: 16];
            THIRD_SEL_MID: third = st_r.acc[s][THIRD_MID_LSB +: 16];
            THIRD_SEL_LO: third = st_r.acc[s][THIRD_LO_LSB +: 16];
            default: third = 16'h0;
          endcase
          red = red + 20'($signed(third));
        end
        default: begin
          known = 1'b0;
        end
      endcase

      if (legal && known && (fn != ACCUM_SUM_REDUCE_OP)) begin
        st_nxt.acc[s][BACC_HI_LSB +: BACC_W] = b_hi;
        st_nxt.acc[s][BACC_LO_LSB +: BACC_W] = b_lo;
      end

      // Multiplies move the accumulator unshifted; the element chose the operand.
      if ((fn == ABS_DIFF_SUM_OP) || (fn == ABS_DIFF_SUM_ACCUM_OP)) begin
        st_nxt.wb.data[s] = issue_i.first_src[s];
      end else if ((fn == BYTE_MUL_LOAD_OP) || (fn == BYTE_MUL_LOAD_NEG_OP)
                   || (fn == BYTE_MUL_ADD_OP) || (fn == BYTE_MUL_SUB_OP)) begin
        st_nxt.wb.data[s] = {vba_clamp_byte(b_hi, 3'h0), vba_clamp_byte(b_lo, 3'h0)};
      end else begin
        st_nxt.wb.data[s] = {vba_clamp_byte(b_hi, sh), vba_clamp_byte(b_lo, sh)};
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sum reduction result, clamped to a signed halfword in the low slice.
    if (red > SUM_MAX) begin
      red_clamped = 16'h7fff;
    end else if (red < SUM_MIN) begin
      red_clamped = 16'h8000;
    end else begin
      red_clamped = red[15:0];
    end
    if (fn == ACCUM_SUM_REDUCE_OP) begin
      st_nxt.wb.data = '0;
      st_nxt.wb.data[0] = red_clamped;
    end

    if (legal) begin
      st_nxt.wb.valid = known;
      st_nxt.wb.dest_vreg = ins.dest_vreg;
      st_nxt.illegal = !known;
    end else begin
      // Nothing is written back, so the last data needs no refresh.
      st_nxt.wb.data = st_r.wb.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_r.acc <= {SLICES{ACC_RST}};
      st_r.wb.valid <= 1'b0;
      st_r.wb.dest_vreg <= VREG_RST;
      st_r.wb.data <= '0;
      st_r.illegal <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_o = st_r.wb;
  assign illegal_o = st_r.illegal;

endmodule : vba_unit

`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the byte arithmetic and accumulator unit.
// Assumes the issuer model drives the unit and the checker is bound in.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vba_pkg::*;
  logic clock_i;
  logic reset_i;
  vba_issue_t issue;
  vba_wb_t wb;
  logic illegal;
  int fail_count;
  int total_checks;
  vba_unit u_dut (.clock_i(clock_i), .reset_i(reset_i), .issue_i(issue), .wb_o(wb),
    .illegal_o(illegal));
  vba_issuer_model u_iss (.clock_i(clock_i), .issue_o(issue));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic vba_instr_t mk(input logic [5:0] f, input logic [3:0] e);
    return {COPROCESSOR_MAJOR_OPCODE, 1'b1, e, 5'h03, 5'h04, f[4:0], f};
  endfunction : mk
  // Shift, optional round and clamp of one byte accumulator value.
  function automatic logic [7:0] br(input int s, input int e);
    int v;
    v = (s + (e > 0 ? 1 << (e - 1) : 0)) >>> e;
    return v > 255 ? 8'hff : (v < 0 ? 8'h00 : v[7:0]);
  endfunction : br
  task automatic op(input logic [5:0] f, input logic [3:0] e, input logic [15:0] a,
      input logic [15:0] b, input logic [15:0] x);
    u_iss.send(mk(f, e), {8{a}}, {8{b}});
    chk("valid", 1, wb.valid);
    chk("dest", f[4:0], wb.dest_vreg);
    chk("data", {8{x}}, wb.data);
  endtask : op
  // Source registers are deliberately nonzero: the reduction must not use them.
  task automatic red(input logic [3:0] e, input logic [15:0] x);
    u_iss.send(mk(ACCUM_SUM_REDUCE_OP, e), {8{16'h5a5a}}, {8{16'ha5a5}});
    chk("sum", {112'h0, x}, wb.data);
  endtask : red
  task automatic t_addsub();
    for (int e = 0; e < 8; e++) begin
      op(BYTE_ADD_OP, e[3:0], 16'h8005, 16'h9002, {br(32'h110, e), br(7, e)});
      op(BYTE_SUB_OP, e[3:0], 16'h8005, 16'h9002, {br(-16, e), br(3, e)});
    end
  endtask : t_addsub
  task automatic t_accum();
    op(BYTE_ADD_OP, 4'h0, 16'h8005, 16'h9002, 16'hff07);
    op(BYTE_ADD_ACCUM_OP, 4'h2, 16'h8005, 16'h9002, 16'h8803);
    op(BYTE_SUB_ACCUM_OP, 4'h1, 16'h8005, 16'h9002, 16'hff08);
  endtask : t_accum
  task automatic t_sad();
    op(ABS_DIFF_SUM_OP, 4'h5, 16'h1080, 16'h3070, 16'h1080);
    op(ABS_DIFF_SUM_ACCUM_OP, 4'h0, 16'h1080, 16'h3070, 16'h1080);
    op(BYTE_PAIR_SUM_ACCUM_OP, 4'h1, 16'h0000, 16'h0000, 16'h0030);
    op(BYTE_PAIR_SUM_OP, 4'h1, 16'h0102, 16'h0305, 16'h0005);
  endtask : t_sad
  task automatic t_mul();
    op(BYTE_MUL_LOAD_OP, 4'h0, 16'h0203, 16'h0405, 16'h080f);
    op(BYTE_MUL_ADD_OP, 4'h0, 16'h0203, 16'h0405, 16'h101e);
    op(BYTE_MUL_SUB_OP, 4'h0, 16'h0203, 16'h0405, 16'h080f);
    op(BYTE_MUL_LOAD_NEG_OP, 4'h0, 16'h0203, 16'h0405, 16'h0000);
    op(BYTE_MUL_ADD_OP, 4'h0, 16'h0203, 16'h0405, 16'h0000);
    u_iss.send(mk(BYTE_MUL_LOAD_OP, 4'ha), {8{16'h0203}}, 128'h0405 << 32);
    chk("scalar", {8{16'h080f}}, wb.data);
    red(4'h2, 16'h0078);
    red(4'h1, 16'h0100);
    red(4'h0, 16'h0000);
    op(BYTE_MUL_LOAD_OP, 4'h0, 16'h7f7f, 16'hffff, 16'hffff);
    red(4'h2, 16'h7fff);
    op(BYTE_MUL_LOAD_NEG_OP, 4'h0, 16'h7f7f, 16'hffff, 16'h0000);
    red(4'h2, 16'h8000);
  endtask : t_mul
  task automatic t_refuse();
    vba_instr_t w;
    w = mk(BYTE_ADD_OP, 4'h0);
    w.co = 1'b0;
    u_iss.send(w, '0, '0);
    chk("ignored", 0, wb.valid);
    u_iss.send(mk(6'h3f, 4'h0), '0, '0);
    chk("illegal", 1, illegal);
    chk("no write", 0, wb.valid);
    u_iss.idle();
    chk("pulse", 0, illegal);
  endtask : t_refuse
  // A reset in mid-run must clear the accumulators as well as the write-back.
  task automatic t_reset();
    reset_i = 1'b1;
    @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    chk("reset data", '0, wb.data);
    chk("reset illegal", 0, illegal);
    op(BYTE_ADD_ACCUM_OP, 4'h0, 16'h0102, 16'h0304, 16'h0406);
  endtask : t_reset
  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    total_checks = 0;
    reset_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    chk("reset data", '0, wb.data);
    chk("reset valid", 0, wb.valid);
    t_addsub();
    u_iss.idle();
    t_accum();
    t_sad();
    u_iss.idle();
    t_mul();
    t_refuse();
    t_reset();
    report_and_stop();
  end
  // The run needs well under 100 cycles; this only cuts a hang short.
  initial begin
    #(40 * 1000);
    fail_count++;
    report_and_stop();
  end
endmodule : tb

`default_nettype wire

// ===== tb/vba_issuer_model.sv
// Stand-in for the issuing pipeline: one instruction per call, back to back if wanted.
// Assumes every call starts just after a rising clock edge.
`default_nettype none

module vba_issuer_model
  import vba_pkg::*;
(
  input wire logic clock_i,
  output var vba_pkg::vba_issue_t issue_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial issue_o = '0;
  //////////////////////////////////////////////////////////////////////////
  // The unit never stalls, so a request is taken at the next edge; it stays driven, valid high, until the next call.
  task automatic send(input vba_instr_t w, input vba_vec_t a, input vba_vec_t b);
    issue_o.valid = 1'b1;
    issue_o.instr = w;
    issue_o.first_src = a;
    issue_o.second_src = b;
    @(posedge clock_i);
    #1;
  endtask : send
  // Released lines show the inverse of the last value, so stale data cannot pass.
  task automatic idle();
    vba_issue_t t;
    t = ~issue_o;
    t.valid = 1'b0;
    issue_o = t;
    @(posedge clock_i);
    #1;
  endtask : idle
endmodule : vba_issuer_model

`default_nettype wire

// ===== tb/vba_unit_properties.sv
// Port assertions for the byte arithmetic and accumulator unit.
// Assumes it is bound onto vba_unit: one clock, asynchronous active-high reset.
`default_nettype none

module vba_unit_properties
  import vba_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire vba_pkg::vba_issue_t issue_i,
  input wire vba_pkg::vba_wb_t wb_o,
  input wire logic illegal_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic taken;
  logic known;
  logic [8:0] s0;
  assign taken = issue_i.valid && issue_i.instr.major == COPROCESSOR_MAJOR_OPCODE
    && issue_i.instr.co;
  assign known = issue_i.instr.func inside {[6'h20:6'h2c]};
  // Only slice 0 low byte is modelled here; the bench covers the other slices.
  assign s0 = issue_i.first_src[0][7:0] + issue_i.second_src[0][7:0];
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  //////////////////////////////////////////////////////////////////////////
  AST_ANSWER:
    assert property (taken && known |=> wb_o.valid && !illegal_o) else $error("no write-back");
  AST_REFUSE:
    assert property (taken && !known |=> illegal_o && !wb_o.valid) else $error("no refusal");
  AST_IGNORE:
    assert property (!taken |=> !wb_o.valid && !illegal_o) else $error("stray pulse");
  AST_DEST:
    assert property (taken |=> wb_o.dest_vreg == $past(issue_i.instr.dest_vreg))
      else $error("wrong destination");
  AST_SAD_COPY:
    assert property (taken && issue_i.instr.func inside {ABS_DIFF_SUM_OP, ABS_DIFF_SUM_ACCUM_OP}
      |=> wb_o.data == $past(issue_i.first_src)) else $error("first source not copied");
  AST_SUM_LOW:
    assert property (taken && issue_i.instr.func == ACCUM_SUM_REDUCE_OP
      |=> wb_o.data[7:1] == '0) else $error("reduction upper slices not zero");
  AST_ADD_CLAMP:
    assert property (taken && issue_i.instr.func == BYTE_ADD_OP && issue_i.instr.elem == 4'h0
      |=> wb_o.data[0][7:0] == ($past(s0[8]) ? 8'hff : $past(s0[7:0])))
      else $error("byte sum not clamped");
  AST_HOLD:
    assert property (!taken |=> $stable(wb_o.data) && $stable(wb_o.dest_vreg))
      else $error("write-back data moved");
endmodule : vba_unit_properties

bind vba_unit vba_unit_properties u_props (.clock_i(clock_i), .reset_i(reset_i),
  .issue_i(issue_i), .wb_o(wb_o), .illegal_o(illegal_o));

`default_nettype wire
